/* File: design/tws_target.sv */
// two-wire serial memory target: bus engine, array and write timer
`timescale 1ns/1ps
`default_nettype none
`include "tws_defines.svh"
module tws_target #(
    parameter int PROG_CYCLES = `TWS_PROG_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire tws_pkg::tws_pins_t bus_in,
    output logic sda_oe_n,
    input wire logic [2:0] chip_select_pins,
    input wire logic write_protect,
    output logic busy
);
    import tws_pkg::*;

    // ==========================================================
    // link-domain reset and input synchronisers
    // ==========================================================
    logic [1:0] lrst_q; // reset carried into the link domain
    logic [1:0] scl_s_q; // scl sync pair, stage 0 only feeds stage 1
    logic [1:0] sda_s_q; // sda sync pair
    logic scl_q; // previous synced scl
    logic sda_q; // previous synced sda
    logic lrst;

    // reset is level, two flops suffice
    always_ff @(posedge link_clk)
    begin
        lrst_q <= {lrst_q[0], rst};
    end
    assign lrst = lrst_q[1];

    // both lines pass two flops before any decode
    always_ff @(posedge link_clk)
    begin
        scl_s_q <= {scl_s_q[0], bus_in.scl};
        sda_s_q <= {sda_s_q[0], bus_in.sda};
        scl_q <= scl_s_q[1];
        sda_q <= sda_s_q[1];
    end

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    assign scl_rise = scl_s_q[1] & ~scl_q;
    assign scl_fall = ~scl_s_q[1] & scl_q;
    assign start_c = scl_s_q[1] & scl_q & sda_q & ~sda_s_q[1];
    assign stop_c = scl_s_q[1] & scl_q & ~sda_q & sda_s_q[1];

    // ==========================================================
    // busy level crossing into the link domain
    // ==========================================================
    logic busy_q; // core-domain programming flag
    logic [1:0] busy_s_q; // synchronised copy for the bus engine
    // busy is a slow level held for many link clocks, so a plain two-flop
    // pair is enough; no pulse can be lost in the crossing
    always_ff @(posedge link_clk)
    begin
        busy_s_q <= {busy_s_q[0], busy_q};
    end

    // ==========================================================
    // bus engine
    // ==========================================================
    tws_state_t st_q; // serial state
    logic [3:0] bit_q; // bit index within the nine-clock slot
    logic [7:0] sh_q; // receive shifter
    logic [7:0] tx_q; // transmit shifter
    logic [13:0] ptr_q; // word address pointer, link side
    logic [5:0] hi_q; // held upper address byte
    logic acking_q; // driving ack on the ninth clock
    logic oe_n_q; // open-drain enable, low pulls sda low
    logic wr_seen_q; // a data byte arrived in this write
    logic wb_stb_q; // one-clock strobe: latched byte ready for the array
    logic ctog_q; // toggles to commit on stop
    tws_wbyte_t wb_q; // write byte latched for the link-side array write
    logic [7:0] rd_byte; // array byte at pointer
    logic [1:0] wp_s_q; // write protect sync pair
    logic write_protect_l; // synced write protect level
    logic [2:0] cs_s0_q; // chip select first sync stage
    logic [2:0] cs_s1_q; // chip select second stage, the only one decoded

    // first memory byte request uses array read below
    logic [7:0] mem [0:`TWS_MEM_DEPTH-1];

    // combinational helpers
    function automatic logic addr_hit(input logic [7:0] b, input logic [2:0] cs);
        // floating selects come in as low through the pad pull
        addr_hit = (b[7:4] == `TWS_CLASS_CODE) && (b[3:1] == cs);
    endfunction

    function automatic logic [13:0] page_inc(input logic [13:0] a);
        page_inc = {a[13:6], a[5:0] + 6'h01};
    endfunction

    assign rd_byte = mem[ptr_q];

    // serial state machine; start wins over anything in flight except link reset and the programming lockout
    // priority, highest first: link reset, programming lockout, start,
    // stop, then the clock edges. the lockout sits above start so that a
    // controller polling during the timed cycle sees no acknowledge at all.
    // bit_q counts rises within a nine-clock slot: 0..7 shift data in, 8 is
    // the acknowledge clock. decisions are taken on the fall that ends the
    // eighth bit, so sda only moves while scl is low.
    // limitation: scl high and low phases must each span several link
    // clocks, since both lines are oversampled through two flops and an
    // edge history flop.
    always_ff @(posedge link_clk)
    begin
        wb_stb_q <= 1'b0; // default: no byte for the array this clock
        if (lrst)
        begin
            st_q <= TWS_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            tx_q <= 8'hFF;
            ptr_q <= 14'h0000;
            hi_q <= 6'h00;
            acking_q <= 1'b0;
            oe_n_q <= 1'b1;
            wr_seen_q <= 1'b0;
            wb_stb_q <= 1'b0;
            ctog_q <= 1'b0;
            wb_q <= '0;
        end
        else if (busy_s_q[1])
        begin
            // ignore the bus entirely while programming
            st_q <= TWS_IDLE;
            oe_n_q <= 1'b1;
            acking_q <= 1'b0;
            wr_seen_q <= 1'b0;
        end
        else if (start_c)
        begin
            st_q <= TWS_DEV;
            bit_q <= 4'h0;
            oe_n_q <= 1'b1;
            acking_q <= 1'b0;
            wr_seen_q <= 1'b0;
        end
        else if (stop_c)
        begin
            // write stop commits; read stop just idles
            if (st_q == TWS_WDATA && wr_seen_q && !write_protect_l)
            begin
                ctog_q <= ~ctog_q;
            end
            st_q <= TWS_IDLE;
            oe_n_q <= 1'b1;
            wr_seen_q <= 1'b0;
        end
        else if (st_q != TWS_IDLE && scl_rise)
        begin
            // sample on rising clock
            if (bit_q < 4'h8)
            begin
                sh_q <= {sh_q[6:0], sda_s_q[1]};
                bit_q <= bit_q + 4'h1;
            end
            else
            begin
                bit_q <= 4'h0;
                // ninth clock: a read master nack ends the stream
                if (st_q == TWS_RDATA && sda_s_q[1])
                begin
                    st_q <= TWS_IDLE;
                end
            end
        end
        else if (st_q != TWS_IDLE && scl_fall)
        begin
            // drive changes only on falling clock
            if (bit_q == 4'h8 && st_q != TWS_RDATA)
            begin
                acking_q <= 1'b1;
                unique case (st_q)
                    TWS_DEV:
                    begin
                        if (addr_hit(sh_q, cs_s1_q))
                        begin
                            oe_n_q <= 1'b0;
                            st_q <= sh_q[0] ? TWS_RDATA : TWS_ADDR_HI;
                            tx_q <= rd_byte;
                        end
                        else
                        begin
                            st_q <= TWS_IDLE;
                            acking_q <= 1'b0;
                        end
                    end
                    TWS_ADDR_HI:
                    begin
                        hi_q <= sh_q[5:0];
                        oe_n_q <= 1'b0;
                        st_q <= TWS_ADDR_LO;
                    end
                    TWS_ADDR_LO:
                    begin
                        ptr_q <= {hi_q, sh_q};
                        oe_n_q <= 1'b0;
                        st_q <= TWS_WDATA;
                    end
                    TWS_WDATA:
                    begin
                        wb_q <= '{addr: ptr_q, data: sh_q};
                        wb_stb_q <= 1'b1;
                        ptr_q <= page_inc(ptr_q);
                        wr_seen_q <= 1'b1;
                        oe_n_q <= 1'b0;
                    end
                    default:
                    begin
                        oe_n_q <= 1'b1;
                    end
                endcase
            end
            else if (bit_q == 4'h0 && acking_q)
            begin
                // release after ack; read starts first data bit
                acking_q <= 1'b0;
                oe_n_q <= (st_q == TWS_RDATA) ? tx_q[7] : 1'b1;
                if (st_q == TWS_RDATA)
                begin
                    tx_q <= {tx_q[6:0], 1'b1};
                end
            end
            else if (st_q == TWS_RDATA)
            begin
                if (bit_q == 4'h8)
                begin
                    // release for the controller's ack, advance pointer
                    oe_n_q <= 1'b1;
                    ptr_q <= ptr_q + 14'h0001;
                    acking_q <= 1'b0;
                end
                else if (bit_q == 4'h0)
                begin
                    tx_q <= {rd_byte[6:0], 1'b1};
                    oe_n_q <= rd_byte[7];
                end
                else
                begin
                    oe_n_q <= tx_q[7];
                    tx_q <= {tx_q[6:0], 1'b1};
                end
            end
        end
    end

    // write protect, sampled in the link domain through two flops
    always_ff @(posedge link_clk)
    begin
        wp_s_q <= {wp_s_q[0], write_protect};
    end
    assign write_protect_l = wp_s_q[1];

    // chip selects are pins too: two flops before the address compare
    always_ff @(posedge link_clk)
    begin
        cs_s0_q <= chip_select_pins;
        cs_s1_q <= cs_s0_q;
    end

    assign sda_oe_n = oe_n_q;

    // ==========================================================
    // array write: each byte written on link clock, busy timed by core
    // ==========================================================
    // each acked byte is latched with its address and written one link clock
    // later; the core timer only gates when the bus may see the array again.
    // trade-off: bytes land before the closing stop, so a write cut short by
    // a fresh start still leaves the bytes already acknowledged in place
    always_ff @(posedge link_clk)
    begin
        // protect is looked at here, so a pin raised during the byte wins
        if (wb_stb_q && !write_protect_l)
        begin
            mem[wb_q.addr] <= wb_q.data;
        end
    end

    // ==========================================================
    // core domain: commit toggle and programming timer
    // ==========================================================
    logic [2:0] ct_s_q; // commit toggle sync plus edge history
    logic [31:0] tmr_q; // programming countdown
    always_ff @(posedge clock)
    begin
        ct_s_q <= {ct_s_q[1:0], ctog_q};
    end

    // timed cycle; exactly PROG_CYCLES keeps within the limit
    // a commit toggle edge loads the countdown; busy then stands for
    // PROG_CYCLES core clocks. a second commit while busy cannot arrive,
    // because the bus engine is locked out until busy drops again.
    // the bus sees busy two link clocks late, and the stop that began the
    // cycle was seen some link clocks before the toggle got here: both
    // delays widen the polling window, not the programming time.
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            busy_q <= 1'b0;
            tmr_q <= 32'h0;
        end
        else if (ct_s_q[2] != ct_s_q[1])
        begin
            busy_q <= 1'b1;
            tmr_q <= 32'(PROG_CYCLES - 1);
        end
        else if (busy_q)
        begin
            if (tmr_q == 32'h0)
            begin
                busy_q <= 1'b0;
            end
            else
            begin
                tmr_q <= tmr_q - 32'h1;
            end
        end
    end

    assign busy = busy_q;
endmodule
`default_nettype wire

/* File: design/tws_defines.svh */
// constants for the two-wire serial memory target
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
`define TWS_CLASS_CODE 4'hA
`define TWS_MEM_DEPTH 16384
`define TWS_PAGE_BYTES 64
`define TWS_ADDR_W 14
`define TWS_PAGE_LOW_W 6
`define TWS_CLK_MHZ 100
`define TWS_PROG_MS 5
`define TWS_PROG_CYCLES (`TWS_PROG_MS * 1000 * `TWS_CLK_MHZ)
`endif

/* File: design/tws_pkg.sv */
// types shared by the two-wire serial memory target
package tws_pkg;
    // bus-side serial states
    typedef enum logic [2:0] {
        TWS_IDLE,
        TWS_DEV,
        TWS_ADDR_HI,
        TWS_ADDR_LO,
        TWS_WDATA,
        TWS_RDATA
    } tws_state_t;
    // one received write byte handed to the link-side array write
    typedef struct packed {
        logic [13:0] addr;
        logic [7:0] data;
    } tws_wbyte_t;
    // pin group on the serial side
    typedef struct packed {
        logic scl;
        logic sda;
    } tws_pins_t;
endpackage

/* File: tb/tws_target_checker.sv */
// port-level assertion checker for the two-wire memory target
`timescale 1ns/1ps
`default_nettype none
module tws_target_checker #(
    parameter int PROG_CYCLES = 50
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic link_clk,
    input wire tws_pkg::tws_pins_t bus_in,
    input wire logic sda_oe_n,
    input wire logic [2:0] chip_select_pins,
    input wire logic write_protect,
    input wire logic busy
);
    import tws_pkg::*;
    // ========
    // helper: length of the running programming cycle
    int busy_cnt_q;
    always_ff @(posedge clock)
    begin
        if (rst || !busy)
            busy_cnt_q <= 0;
        else
            busy_cnt_q <= busy_cnt_q + 1;
    end
    // ========
    // properties
    // helper: clocks spent in reset, saturating; the link side needs a few
    // link edges of reset before its outputs are defined
    int rst_cnt_q;
    always_ff @(posedge clock)
    begin
        if (!rst)
        begin
            rst_cnt_q <= 0;
        end
        else if (rst_cnt_q < 15)
        begin
            rst_cnt_q <= rst_cnt_q + 1;
        end
    end
    property p_reset_idle;
        @(posedge clock) rst && rst_cnt_q >= 10 |=> sda_oe_n && !busy;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("outputs busy in reset");
    property p_drive_on_fall;
        @(posedge link_clk) disable iff (rst)
        $changed(sda_oe_n) |-> !bus_in.scl && $past(bus_in.scl, 8);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("sda moved off fall");
    property p_steady_high;
        @(posedge link_clk) disable iff (rst)
        bus_in.scl && $past(bus_in.scl) |-> $stable(sda_oe_n);
    endproperty
    a_steady_high: assert property (p_steady_high) else $error("sda moved, scl high");
    property p_ack_hold;
        @(posedge link_clk) disable iff (rst) $fell(sda_oe_n) |-> !sda_oe_n [*8];
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("low bit cut short");
    property p_quiet_busy;
        @(posedge clock) disable iff (rst) busy |-> sda_oe_n;
    endproperty
    a_quiet_busy: assert property (p_quiet_busy) else $error("drive while busy");
    property p_wp_block;
        @(posedge clock) disable iff (rst)
        write_protect && $past(write_protect, 8) |-> !$rose(busy);
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("protected write ran");
    property p_prog_stop;
        @(posedge clock) disable iff (rst) $rose(busy) |-> bus_in.scl && bus_in.sda;
    endproperty
    a_prog_stop: assert property (p_prog_stop) else $error("busy without stop");
    property p_prog_bound;
        @(posedge clock) disable iff (rst) busy_cnt_q <= PROG_CYCLES + 4;
    endproperty
    a_prog_bound: assert property (p_prog_bound) else $error("programming too long");
    c_prog: cover property (@(posedge clock) $rose(busy));
    c_ack: cover property (@(posedge link_clk) $fell(sda_oe_n));
    c_wp: cover property (@(posedge clock) write_protect && !bus_in.scl);
endmodule
bind tws_target tws_target_checker #(.PROG_CYCLES(PROG_CYCLES)) tws_target_checker_i (
    .clock(clock), .rst(rst), .link_clk(link_clk), .bus_in(bus_in), .sda_oe_n(sda_oe_n),
    .chip_select_pins(chip_select_pins), .write_protect(write_protect), .busy(busy));
`default_nettype wire

/* File: tb/tws_ctrl_model.sv */
// behavioural two-wire bus controller facing the target
`timescale 1ns/1ps
`default_nettype none
module tws_ctrl_model (
    input wire logic clock,
    input wire logic sda_in,
    output logic scl,
    output logic sda_pull
);
    // ========
    // idle bus: both lines released high
    initial
    begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    // quarter bit of 200 ns, moved just after a core edge
    task automatic qw();
        repeat (20) @(posedge clock);
        #1;
    endtask
    // sda falls while scl is high
    task automatic start_c();
        sda_pull = 1'b0;
        qw();
        scl = 1'b1;
        qw();
        sda_pull = 1'b1;
        qw();
        scl = 1'b0;
        qw();
    endtask
    // sda rises while scl is high
    task automatic stop_c();
        sda_pull = 1'b1;
        qw();
        scl = 1'b1;
        qw();
        sda_pull = 1'b0;
        qw();
        qw();
    endtask
    // data set only while scl is low, sampled mid high
    task automatic bit_c(input logic b, output logic r);
        sda_pull = !b;
        qw();
        scl = 1'b1;
        qw();
        r = sda_in;
        qw();
        scl = 1'b0;
        qw();
    endtask
    // eight bits msb first, then the ninth clock
    task automatic byte_c(input logic [7:0] d, input logic nk, output logic [7:0] r,
                          output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], r[i]);
        bit_c(nk, ack);
    endtask
endmodule
`default_nettype wire

/* File: tb/tws_target_tb.sv */
// self-checking bench for the two-wire memory target
`timescale 1ns/1ps
`default_nettype none
module tws_target_tb;
    import tws_pkg::*;
    localparam int PROG = 2000; // long enough to poll during it
    localparam logic [2:0] CS = 3'h5;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic write_protect = 1'b0;
    logic [2:0] chip_select_pins = CS;
    logic scl;
    logic sda_pull;
    logic sda_oe_n;
    logic busy;
    tws_pins_t bus;
    int mismatches = 0;
    int cmp_count = 0;
    int cycles = 0;
    // wired-and of both pull-downs over the pull-up
    assign bus = {scl, ~(sda_pull | ~sda_oe_n)};
    always #5 clock = ~clock;
    initial
    begin
        #7;
        forever #16 link_clk = ~link_clk;
    end
    tws_target #(.PROG_CYCLES(PROG)) tws_target_i (
        .clock(clock), .rst(rst), .link_clk(link_clk), .bus_in(bus), .sda_oe_n(sda_oe_n),
        .chip_select_pins(chip_select_pins), .write_protect(write_protect), .busy(busy));
    tws_ctrl_model tws_ctrl_model_i (.clock(clock), .sda_in(bus.sda), .scl(scl),
        .sda_pull(sda_pull));
    // ========
    // compares and verdict
    task automatic check_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ========
    // bus helpers; low ack bit means accepted
    task automatic tx(input logic [7:0] b, input logic exp_ack);
        logic [7:0] r;
        logic a;
        tws_ctrl_model_i.byte_c(b, 1'b1, r, a);
        check_bit(a, exp_ack);
    endtask
    task automatic write_seq(input logic [15:0] a, input int n, input logic [23:0] d);
        tws_ctrl_model_i.start_c();
        tx({4'hA, CS, 1'b0}, 1'b0);
        tx(a[15:8], 1'b0);
        tx(a[7:0], 1'b0);
        for (int i = 0; i < n; i++)
            tx(d[23 - 8 * i -: 8], 1'b0);
        tws_ctrl_model_i.stop_c();
        repeat (30) @(posedge clock);
        #1;
    endtask
    task automatic read_seq(input logic [15:0] a, input int n, input logic [23:0] e);
        logic [7:0] r;
        logic k;
        tws_ctrl_model_i.start_c();
        tx({4'hA, CS, 1'b0}, 1'b0);
        tx(a[15:8], 1'b0);
        tx(a[7:0], 1'b0);
        tws_ctrl_model_i.start_c();
        tx({4'hA, CS, 1'b1}, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            tws_ctrl_model_i.byte_c(8'hFF, i == n - 1, r, k);
            check_byte(r, e[23 - 8 * i -: 8]);
        end
        tws_ctrl_model_i.stop_c();
    endtask
    task automatic wait_prog();
        int k;
        k = 0;
        while (busy === 1'b1 && k < PROG + 100)
        begin
            @(posedge clock);
            k++;
        end
        #1;
        check_bit(busy, 1'b0);
    endtask
    // ========
    // scenarios
    task automatic t_reset();
        check_bit(sda_oe_n, 1'b1);
        check_bit(busy, 1'b0);
        $display("test reset done");
    endtask
    task automatic t_address();
        tws_ctrl_model_i.start_c();
        tx({4'hB, CS, 1'b0}, 1'b1);
        tws_ctrl_model_i.start_c();
        tx({4'hA, ~CS, 1'b0}, 1'b1);
        tws_ctrl_model_i.stop_c();
        $display("test address done");
    endtask
    task automatic t_byte_write();
        write_seq(16'hC123, 1, 24'h5A0000);
        check_bit(busy, 1'b1);
        tws_ctrl_model_i.start_c();
        tx({4'hA, CS, 1'b0}, 1'b1);
        tws_ctrl_model_i.stop_c();
        wait_prog();
        read_seq(16'h0123, 1, 24'h5A0000);
        $display("test byte write done");
    endtask
    task automatic t_page();
        write_seq(16'h007E, 3, 24'h112233);
        wait_prog();
        read_seq(16'h007E, 2, 24'h112200);
        read_seq(16'h0040, 1, 24'h330000);
        $display("test page done");
    endtask
    task automatic t_protect();
        write_protect = 1'b1;
        write_seq(16'h0123, 1, 24'hA50000);
        check_bit(busy, 1'b0);
        read_seq(16'h0123, 1, 24'h5A0000);
        write_protect = 1'b0;
        $display("test protect done");
    endtask
    // hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            mismatches++;
            print_verdict();
        end
    end
    initial
    begin
        // reset stretched to cover four link edges
        repeat (14) @(posedge clock);
        #1;
        rst = 1'b0;
        repeat (20) @(posedge clock);
        #1;
        t_reset();
        t_address();
        t_byte_write();
        t_page();
        t_protect();
        print_verdict();
    end
endmodule
`default_nettype wire
